// ===== logic/i2c_paged_pkg.sv
// package: constants, states and carriers of the paged i2c register port
package i2c_paged_pkg;

  // target address
  localparam logic [2:0] ADDR_HI     = 3'h5;
  localparam logic [3:0] ADDR_LO_GND = 4'h0;
  localparam logic [3:0] ADDR_LO_SCL = 4'h5;
  localparam logic [3:0] ADDR_LO_SDA = 4'ha;
  localparam logic [3:0] ADDR_LO_VCC = 4'hf;

  typedef enum logic [1:0] {
    STRAP_GND = 2'b00,
    STRAP_SCL = 2'b01,
    STRAP_SDA = 2'b10,
    STRAP_VCC = 2'b11
  } strap_e;

  // register offsets and values
  localparam logic [7:0] OFS_IRQ_MASK  = 8'hf0;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'hf1;
  localparam logic [7:0] OFS_PAGE_SEL  = 8'hfd;
  localparam logic [7:0] OFS_UNLOCK    = 8'hfe;
  localparam logic [7:0] UNLOCK_CODE   = 8'hc5;
  localparam logic [7:0] UNLOCK_RST    = 8'h00;
  localparam logic [7:0] PAGE_RST      = 8'h00;
  localparam logic [7:0] PAGE_MAX      = 8'h03;
  localparam logic [7:0] LED_CTRL_PAGE = 8'h00;
  localparam logic [7:0] FAULT_LO      = 8'h18;
  localparam logic [7:0] FAULT_HI      = 8'h47;
  localparam logic [3:0] MASK_RST      = 4'h0;
  localparam logic [4:0] FLAGS_RST     = 5'h00;

  // mask and flag fields
  localparam int MASK_OPEN   = 0;
  localparam int MASK_SHORT  = 1;
  localparam int MASK_BREATH = 2;
  localparam int MASK_AUTO   = 3;
  localparam int FLAG_OPEN   = 0;
  localparam int FLAG_SHORT  = 1;
  localparam int FLAG_BR_LO  = 2;
  localparam int FLAG_BR_HI  = 4;
  localparam int NUM_EVT     = 5;

  localparam logic [3:0] BYTE_BITS = 4'h8;

  // timing
  localparam int CLK_PERIOD_NS     = 25;
  localparam int AUTO_CLEAR_NS     = 8_000_000;
  localparam int AUTO_CLEAR_CYCLES = (AUTO_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_ADDR   = 4'b0001,
    ST_AACK   = 4'b0010,
    ST_REG    = 4'b0011,
    ST_RACK   = 4'b0100,
    ST_WDATA  = 4'b0101,
    ST_WACK   = 4'b0110,
    ST_RDATA  = 4'b0111,
    ST_RDACK  = 4'b1000
  } st_e;

  typedef struct packed {
    logic [1:0] page;
    logic [7:0] addr;
    logic [7:0] data;
  } page_wr_s;

endpackage : i2c_paged_pkg

// ===== logic/bit_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // reset to the pin's idle level so no false edge follows reset
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule : bit_sync
`default_nettype wire

// ===== logic/irq_auto_clear.sv
// timer that requests a clear once the interrupt line stays low too long
`timescale 1ns/1ps
`default_nettype none
module irq_auto_clear #(
  parameter int CYCLES = i2c_paged_pkg::AUTO_CLEAR_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_irq_n,
  output logic      o_clear_tgl
);
  logic        irq_n_s;
  logic [31:0] cnt_q;
  logic        tgl_q;

  bit_sync #(.WIDTH(1), .RST_VAL(1'h1)) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async (i_irq_n),
    .o_sync  (irq_n_s)
  );

  // saturates so a single clear is asked per low period
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 32'h0000_0000;
    end else if (irq_n_s) begin
      cnt_q <= 32'h0000_0000;
    end else if (cnt_q <= CYCLES[31:0]) begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tgl_q <= 1'b0;
    end else if (!irq_n_s && cnt_q == CYCLES[31:0]) begin
      tgl_q <= ~tgl_q;
    end
  end

  assign o_clear_tgl = tgl_q;
endmodule : irq_auto_clear
`default_nettype wire

// ===== logic/i2c_paged_register_port.sv
// i2c target port with write-locked page select and interrupt registers
// Behaviour
// - answer address 101 plus 0000 for ground strap, 1111 for supply strap.
// - clock-line strap gives low bits 0101, data-line strap gives 1010.
// - address byte bit zero selects write (0) or read (1).
// - data sampled while clock high; start restarts address comparison.
// - stop condition ends the transfer in progress.
// - on matching address, hold data line low during the whole ack pulse.
// - register-address byte follows, msb first, and is acknowledged.
// - data bytes msb first, each acknowledged by the device.
// - pointer increments by one at each written byte's acknowledge.
// - only unlock, flags and page-0 18h..47h return data on reads.
// - read = write pointer, repeated start, address with read bit, byte out.
// - page select values 0..3 map to pages 0..3; others reserved.
// - after page select write, data writes go to the selected page.
// - page select resets to page 0 and ignores writes while locked.
// - unlock code allows one page select write, then unlock returns to 0.
// - mask bits 0,1,2 enable open, short, breath-loop interrupts; reset zero.
// - mask bit 3 clears interrupt after output low longer than 8 ms.
// - flags: open bit 0, short bit 1, breath patterns bits 2..4; 7..5 zero.
`timescale 1ns/1ps
`default_nettype none
module i2c_paged_register_port #(
  parameter int AUTO_CLEAR_CYCLES = i2c_paged_pkg::AUTO_CLEAR_CYCLES
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_link_clk,
  input  wire logic                     i_scl,
  input  wire logic                     i_sda_i,
  output logic                          o_sda_o,
  output logic                          o_sda_oe,
  input  wire logic [1:0]               i_addr_strap,
  input  wire logic [4:0]               i_evt,
  output logic      [7:0]               o_page_sel,
  output logic                          o_page_wr_valid,
  output var i2c_paged_pkg::page_wr_s   o_page_wr,
  output logic      [7:0]               o_fault_rd_addr,
  input  wire logic [7:0]               i_fault_rd_data,
  output logic                          o_irq_out_n
);

  // pins into the link domain
  logic [3:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_d_q;
  logic       sda_d_q;
  logic [1:0] strap_s;

  bit_sync #(.WIDTH(4), .RST_VAL(4'h3)) u_pin_sync (
    .i_clk   (i_link_clk),
    .i_rst_b (i_rst_b),
    .i_async ({i_addr_strap, i_scl, i_sda_i}),
    .o_sync  (pins_s)
  );
  assign strap_s = pins_s[3:2];
  assign scl_s   = pins_s[1];
  assign sda_s   = pins_s[0];

  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = scl_s & ~scl_d_q;
  assign scl_fall  = ~scl_s & scl_d_q;
  assign start_det = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop_det  = scl_s & scl_d_q & ~sda_d_q & sda_s;

  // own address from the strap
  logic [3:0] addr_lo;
  always_comb begin
    case (i2c_paged_pkg::strap_e'(strap_s))
      i2c_paged_pkg::STRAP_GND: addr_lo = i2c_paged_pkg::ADDR_LO_GND;
      i2c_paged_pkg::STRAP_VCC: addr_lo = i2c_paged_pkg::ADDR_LO_VCC;
      i2c_paged_pkg::STRAP_SCL: addr_lo = i2c_paged_pkg::ADDR_LO_SCL;
      i2c_paged_pkg::STRAP_SDA: addr_lo = i2c_paged_pkg::ADDR_LO_SDA;
      default:                  addr_lo = i2c_paged_pkg::ADDR_LO_GND;
    endcase
  end

  // transfer state
  i2c_paged_pkg::st_e st_q;
  logic [3:0]         cnt_q;
  logic [7:0]         sh_q;
  logic [7:0]         ptr_q;
  logic               oe_q;
  logic               nack_q;
  logic [7:0]         page_q;
  logic [7:0]         unlock_q;
  logic [3:0]         mask_q;
  logic [4:0]         flags_q;
  logic               rd_clr;
  logic               byte_end;
  logic               addr_hit;
  logic               wr_byte;

  assign byte_end = scl_fall && cnt_q == i2c_paged_pkg::BYTE_BITS;
  assign addr_hit = sh_q[7:1] == {i2c_paged_pkg::ADDR_HI, addr_lo};
  assign wr_byte  = st_q == i2c_paged_pkg::ST_WDATA && byte_end;

  // readable locations; anything else returns zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == i2c_paged_pkg::OFS_UNLOCK) begin
      v = unlock_q;
    end else if (a == i2c_paged_pkg::OFS_IRQ_FLAGS) begin
      v = {3'h0, flags_q};
    end else if (page_q == i2c_paged_pkg::LED_CTRL_PAGE &&
                 a >= i2c_paged_pkg::FAULT_LO && a <= i2c_paged_pkg::FAULT_HI) begin
      v = i_fault_rd_data;
    end
    return v;
  endfunction : rd_byte

  logic [7:0] rd_val;
  assign rd_val = rd_byte(ptr_q);

  // bit engine; stop and start win over everything else
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q   <= i2c_paged_pkg::ST_IDLE;
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      oe_q   <= 1'b0;
      nack_q <= 1'b0;
    end else if (stop_det) begin
      st_q <= i2c_paged_pkg::ST_IDLE;
      oe_q <= 1'b0;
    end else if (start_det) begin
      st_q  <= i2c_paged_pkg::ST_ADDR;
      cnt_q <= 4'h0;
      oe_q  <= 1'b0;
    end else begin
      case (st_q)
        i2c_paged_pkg::ST_ADDR, i2c_paged_pkg::ST_REG, i2c_paged_pkg::ST_WDATA: begin
          if (scl_rise) begin
            sh_q  <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_end) begin
            cnt_q <= 4'h0;
            if (st_q != i2c_paged_pkg::ST_ADDR || addr_hit) begin
              oe_q <= 1'b1;
              st_q <= (st_q == i2c_paged_pkg::ST_ADDR) ? i2c_paged_pkg::ST_AACK :
                      (st_q == i2c_paged_pkg::ST_REG)  ? i2c_paged_pkg::ST_RACK :
                                                         i2c_paged_pkg::ST_WACK;
            end else begin
              st_q <= i2c_paged_pkg::ST_IDLE;
            end
          end
        end
        i2c_paged_pkg::ST_AACK: begin
          if (scl_fall) begin
            if (sh_q[0]) begin
              sh_q <= rd_val;
              oe_q <= ~rd_val[7];
              st_q <= i2c_paged_pkg::ST_RDATA;
            end else begin
              oe_q <= 1'b0;
              st_q <= i2c_paged_pkg::ST_REG;
            end
          end
        end
        i2c_paged_pkg::ST_RACK, i2c_paged_pkg::ST_WACK: begin
          if (scl_fall) begin
            oe_q <= 1'b0;
            st_q <= i2c_paged_pkg::ST_WDATA;
          end
        end
        i2c_paged_pkg::ST_RDATA: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_end) begin
            cnt_q <= 4'h0;
            oe_q  <= 1'b0;
            st_q  <= i2c_paged_pkg::ST_RDACK;
          end else if (scl_fall) begin
            sh_q <= {sh_q[6:0], 1'b0};
            oe_q <= ~sh_q[6];
          end
        end
        i2c_paged_pkg::ST_RDACK: begin
          if (scl_rise) begin
            nack_q <= sda_s;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_q <= i2c_paged_pkg::ST_IDLE;
            end else begin
              sh_q <= rd_val;
              oe_q <= ~rd_val[7];
              st_q <= i2c_paged_pkg::ST_RDATA;
            end
          end
        end
        default: begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // register pointer; also steps as each byte is loaded for sending on reads
  logic rd_load;
  assign rd_load = scl_fall && !stop_det && !start_det &&
                   ((st_q == i2c_paged_pkg::ST_AACK && sh_q[0]) ||
                    (st_q == i2c_paged_pkg::ST_RDACK && !nack_q));
  assign rd_clr  = rd_load && ptr_q == i2c_paged_pkg::OFS_IRQ_FLAGS;

  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ptr_q <= 8'h00;
    end else if (!stop_det && !start_det) begin
      if (st_q == i2c_paged_pkg::ST_REG && byte_end) begin
        ptr_q <= sh_q;
      end else if (wr_byte) begin
        ptr_q <= ptr_q + 8'h01;
      end else if (rd_load) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  // register writes
  logic wr_ok;
  assign wr_ok = wr_byte && !stop_det && !start_det;

  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      page_q   <= i2c_paged_pkg::PAGE_RST;
      unlock_q <= i2c_paged_pkg::UNLOCK_RST;
    end else if (wr_ok && ptr_q == i2c_paged_pkg::OFS_PAGE_SEL) begin
      if (unlock_q == i2c_paged_pkg::UNLOCK_CODE) begin
        page_q <= sh_q;
      end
      unlock_q <= i2c_paged_pkg::UNLOCK_RST;
    end else if (wr_ok && ptr_q == i2c_paged_pkg::OFS_UNLOCK) begin
      unlock_q <= sh_q;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask_q <= i2c_paged_pkg::MASK_RST;
    end else if (wr_ok && ptr_q == i2c_paged_pkg::OFS_IRQ_MASK) begin
      mask_q <= sh_q[3:0];
    end
  end

  // page writes; reserved page values send nothing onward
  logic ptr_is_reg;
  assign ptr_is_reg = ptr_q == i2c_paged_pkg::OFS_IRQ_MASK || ptr_q == i2c_paged_pkg::OFS_IRQ_FLAGS ||
                      ptr_q == i2c_paged_pkg::OFS_PAGE_SEL || ptr_q == i2c_paged_pkg::OFS_UNLOCK;

  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_page_wr_valid <= 1'b0;
      o_page_wr       <= '0;
    end else begin
      o_page_wr_valid <= wr_ok && !ptr_is_reg && page_q <= i2c_paged_pkg::PAGE_MAX;
      if (wr_ok) begin
        o_page_wr <= '{page: page_q[1:0], addr: ptr_q, data: sh_q};
      end
    end
  end

  // events cross from the core clock as toggles
  logic [4:0] evt_tgl_q;
  logic [4:0] evt_tgl_s;
  logic [4:0] evt_tgl_d_q;
  logic [4:0] evt_set;

  for (genvar g = 0; g < i2c_paged_pkg::NUM_EVT; g++) begin : g_evt
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        evt_tgl_q[g] <= 1'b0;
      end else if (i_evt[g]) begin
        evt_tgl_q[g] <= ~evt_tgl_q[g];
      end
    end
  end

  bit_sync #(.WIDTH(i2c_paged_pkg::NUM_EVT)) u_evt_sync (
    .i_clk   (i_link_clk),
    .i_rst_b (i_rst_b),
    .i_async (evt_tgl_q),
    .o_sync  (evt_tgl_s)
  );

  // auto clear timer runs on the core clock
  logic clr_tgl;
  logic clr_tgl_s;
  logic clr_tgl_d_q;
  logic auto_clr;

  irq_auto_clear #(.CYCLES(AUTO_CLEAR_CYCLES)) u_auto_clr (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_irq_n     (o_irq_out_n),
    .o_clear_tgl (clr_tgl)
  );

  bit_sync #(.WIDTH(1)) u_clr_sync (
    .i_clk   (i_link_clk),
    .i_rst_b (i_rst_b),
    .i_async (clr_tgl),
    .o_sync  (clr_tgl_s)
  );

  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      evt_tgl_d_q <= 5'h00;
      clr_tgl_d_q <= 1'b0;
    end else begin
      evt_tgl_d_q <= evt_tgl_s;
      clr_tgl_d_q <= clr_tgl_s;
    end
  end

  assign evt_set  = evt_tgl_s ^ evt_tgl_d_q;
  assign auto_clr = (clr_tgl_s ^ clr_tgl_d_q) & mask_q[i2c_paged_pkg::MASK_AUTO];

  // a new event in the clearing cycle survives
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags_q <= i2c_paged_pkg::FLAGS_RST;
    end else begin
      flags_q <= (flags_q & {5{~(rd_clr | auto_clr)}}) | evt_set;
    end
  end

  logic [4:0] flag_en;
  logic       irq_pend;
  assign flag_en  = {{3{mask_q[i2c_paged_pkg::MASK_BREATH]}},
                     mask_q[i2c_paged_pkg::MASK_SHORT], mask_q[i2c_paged_pkg::MASK_OPEN]};
  assign irq_pend = |(flags_q & flag_en);

  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq_out_n <= 1'b1;
    end else begin
      o_irq_out_n <= ~irq_pend;
    end
  end

  assign o_sda_o         = 1'b0;
  assign o_sda_oe        = oe_q;
  assign o_page_sel      = page_q;
  assign o_fault_rd_addr = ptr_q;

  // checks
  addr_ack_a : assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    st_q == i2c_paged_pkg::ST_ADDR && byte_end && addr_hit && !stop_det && !start_det
      |=> o_sda_oe && st_q == i2c_paged_pkg::ST_AACK)
    else $error("matching address not acknowledged");
  addr_miss_a : assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    st_q == i2c_paged_pkg::ST_ADDR && byte_end && !addr_hit && !stop_det && !start_det
      |=> !o_sda_oe && st_q == i2c_paged_pkg::ST_IDLE)
    else $error("foreign address acknowledged");
  ack_hold_a : assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    st_q == i2c_paged_pkg::ST_AACK && !scl_fall && !stop_det && !start_det |=> o_sda_oe)
    else $error("ack released early");
  stop_end_a : assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    stop_det |=> st_q == i2c_paged_pkg::ST_IDLE && !o_sda_oe)
    else $error("stop did not end transfer");
  ptr_step_a : assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    wr_ok |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not step");
  unlock_once_a : assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    wr_ok && ptr_q == i2c_paged_pkg::OFS_PAGE_SEL && unlock_q == i2c_paged_pkg::UNLOCK_CODE
      |=> page_q == $past(sh_q) && unlock_q == i2c_paged_pkg::UNLOCK_RST)
    else $error("unlocked page write wrong");
  page_locked_a : assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    wr_ok && ptr_q == i2c_paged_pkg::OFS_PAGE_SEL && unlock_q != i2c_paged_pkg::UNLOCK_CODE
      |=> $stable(page_q))
    else $error("locked page select changed");
  irq_follow_a : assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    irq_pend |=> !o_irq_out_n)
    else $error("enabled flag without interrupt");
  read_clear_a : assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    rd_clr && evt_set == 5'h00 |=> flags_q == 5'h00 ##1 o_irq_out_n)
    else $error("flag read did not clear");

endmodule : i2c_paged_register_port
`default_nettype wire

// ===== tb/i2c_ctrl_model.sv
// bus controller model: drives scl and its share of sda
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model #(
  parameter int Q = 10
) (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1; // released when idle
  end
  task automatic w;
    repeat (Q) @(posedge i_clk);
  endtask : w
  // extra wait lets the target release sda before a restart
  task automatic start;
    o_sda <= 1'b1;
    w();
    w();
    o_scl <= 1'b1;
    w();
    o_sda <= 1'b0;
    w();
    o_scl <= 1'b0;
    w();
  endtask : start
  task automatic stop;
    o_sda <= 1'b0;
    w();
    o_scl <= 1'b1;
    w();
    o_sda <= 1'b1;
    w();
  endtask : stop
  task automatic bit_io(input logic b, output logic r); // stable while scl high
    o_sda <= b;
    w();
    o_scl <= 1'b1;
    w();
    r = i_sda;
    w();
    o_scl <= 1'b0;
    w();
  endtask : bit_io
  task automatic xfer(input logic [7:0] b, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]); // msb first
    bit_io(a, k);
  endtask : xfer
endmodule : i2c_ctrl_model
`default_nettype wire

// ===== tb/i2c_paged_register_port_tb.sv
// self-checking bench of the paged i2c register port
`timescale 1ns/1ps
`default_nettype none
module i2c_paged_register_port_tb;
  localparam int AC = 50;
  logic                     clk;
  logic                     link_clk;
  logic                     rst_b;
  logic [1:0]               strap;
  logic [4:0]               evt;
  logic                     scl;
  logic                     sda_m;
  logic                     sda_o;
  logic                     sda_oe;
  wire                      sda;
  logic [7:0]               page_sel;
  logic                     wr_v;
  i2c_paged_pkg::page_wr_s  wr;
  logic [7:0]               f_addr;
  wire  [7:0]               f_data;
  logic                     irq_n;
  logic [6:0]               dev;
  int                       errors;
  int                       checks_done;
  i2c_paged_pkg::page_wr_s  wq[$];

  // open drain with pull-up
  assign sda = sda_m & (sda_oe ? sda_o : 1'b1);
  // fault store answers in the same cycle
  assign f_data = f_addr ^ 8'h5a;

  i2c_paged_register_port #(.AUTO_CLEAR_CYCLES(AC)) dut_u (.i_clk(clk), .i_rst_b(rst_b),
    .i_link_clk(link_clk), .i_scl(scl), .i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_addr_strap(strap), .i_evt(evt), .o_page_sel(page_sel), .o_page_wr_valid(wr_v),
    .o_page_wr(wr), .o_fault_rd_addr(f_addr), .i_fault_rd_data(f_data), .o_irq_out_n(irq_n));
  i2c_ctrl_model m_u (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));

  always @(posedge link_clk) if (wr_v === 1'b1) wq.push_back(wr);

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic send(input logic [7:0] b);
    logic [7:0] r;
    logic       k;
    m_u.xfer(b, 1'b1, r, k);
    chk("ack", 18'h0, 18'(k));
  endtask : send
  task automatic wreg(input logic [7:0] r, input logic [7:0] d);
    m_u.start();
    send({dev, 1'b0});
    send(r);
    send(d);
    m_u.stop();
  endtask : wreg
  task automatic rchk(input string n, input logic [7:0] r, input logic [7:0] e);
    logic [7:0] d;
    logic       k;
    m_u.start();
    send({dev, 1'b0});
    send(r);
    m_u.start();
    send({dev, 1'b1});
    m_u.xfer(8'hff, 1'b1, d, k);
    m_u.stop();
    chk(n, 18'(e), 18'(d));
  endtask : rchk
  task automatic pulse(input int i);
    @(posedge clk);
    evt[i] <= 1'b1;
    @(posedge clk);
    evt <= 5'h0;
    repeat (20) @(posedge clk);
  endtask : pulse

  task automatic t_addr;
    logic [3:0] lo [4] = '{4'h0, 4'h5, 4'ha, 4'hf};
    logic [7:0] r;
    logic       k;
    for (int s = 0; s < 4; s++) begin
      strap <= 2'(s);
      repeat (20) @(posedge clk);
      dev = {3'b101, lo[s]};
      m_u.start();
      send({dev, 1'b0});
      m_u.stop();
      m_u.start();
      m_u.xfer({dev ^ 7'h01, 1'b0}, 1'b1, r, k);
      chk("nack", 18'h1, 18'(k));
      m_u.stop();
    end
    $display("t_addr done");
  endtask : t_addr

  task automatic t_page;
    wreg(i2c_paged_pkg::OFS_PAGE_SEL, 8'h01);
    chk("page", 18'h0, 18'(page_sel));
    wreg(i2c_paged_pkg::OFS_UNLOCK, i2c_paged_pkg::UNLOCK_CODE);
    rchk("unlock", i2c_paged_pkg::OFS_UNLOCK, 8'hc5);
    wreg(i2c_paged_pkg::OFS_PAGE_SEL, 8'h01);
    rchk("unlock", i2c_paged_pkg::OFS_UNLOCK, 8'h00);
    wreg(i2c_paged_pkg::OFS_PAGE_SEL, 8'h02);
    chk("page", 18'h1, 18'(page_sel));
    wq.delete();
    m_u.start();
    send({dev, 1'b0});
    send(8'h10);
    send(8'ha1);
    send(8'hb2);
    send(8'hc3);
    m_u.stop();
    chk("count", 18'h3, 18'(wq.size()));
    for (int i = 0; i < 3; i++) chk("wr", {2'h1, 8'(8'h10 + i), 8'(8'ha1 + 8'h11 * i)}, wq[i]);
    // page 4 is reserved: stored but strobes nothing
    for (int p = 0; p < 5; p++) begin
      wreg(i2c_paged_pkg::OFS_UNLOCK, i2c_paged_pkg::UNLOCK_CODE);
      wreg(i2c_paged_pkg::OFS_PAGE_SEL, 8'(p));
      chk("page", 18'(p), 18'(page_sel));
      wq.delete();
      wreg(8'h20, 8'(8'h30 + p));
      chk("count", 18'(p < 4), 18'(wq.size()));
      if (p < 4) chk("wr", {2'(p), 8'h20, 8'(8'h30 + p)}, wq[0]);
    end
    wreg(i2c_paged_pkg::OFS_UNLOCK, i2c_paged_pkg::UNLOCK_CODE);
    wreg(i2c_paged_pkg::OFS_PAGE_SEL, 8'h00);
    $display("t_page done");
  endtask : t_page

  task automatic t_read;
    logic [7:0] d;
    logic       k;
    rchk("fault", 8'h18, 8'h42);
    rchk("fault", 8'h47, 8'h1d);
    rchk("gap", 8'h48, 8'h00);
    rchk("mask", i2c_paged_pkg::OFS_IRQ_MASK, 8'h00);
    // two-byte read: controller acks the first byte, pointer steps
    m_u.start();
    send({dev, 1'b0});
    send(8'h46);
    m_u.start();
    send({dev, 1'b1});
    m_u.xfer(8'hff, 1'b0, d, k);
    chk("burst", 18'h1c, 18'(d));
    m_u.xfer(8'hff, 1'b1, d, k);
    chk("burst", 18'h1d, 18'(d));
    m_u.stop();
    $display("t_read done");
  endtask : t_read

  task automatic t_irq;
    pulse(0);
    chk("irq", 18'h1, 18'(irq_n));
    rchk("flags", i2c_paged_pkg::OFS_IRQ_FLAGS, 8'h01);
    rchk("flags", i2c_paged_pkg::OFS_IRQ_FLAGS, 8'h00);
    wreg(i2c_paged_pkg::OFS_IRQ_MASK, 8'h07);
    pulse(1);
    chk("irq", 18'h0, 18'(irq_n));
    repeat (4 * AC) @(posedge clk);
    chk("irq", 18'h0, 18'(irq_n));
    rchk("flags", i2c_paged_pkg::OFS_IRQ_FLAGS, 8'h02);
    chk("irq", 18'h1, 18'(irq_n));
    pulse(2);
    pulse(3);
    pulse(4);
    rchk("flags", i2c_paged_pkg::OFS_IRQ_FLAGS, 8'h1c);
    wreg(i2c_paged_pkg::OFS_IRQ_MASK, 8'h0f);
    pulse(2);
    chk("irq", 18'h0, 18'(irq_n));
    repeat (AC + 70) @(posedge clk);
    chk("irq", 18'h1, 18'(irq_n));
    rchk("flags", i2c_paged_pkg::OFS_IRQ_FLAGS, 8'h00);
    $display("t_irq done");
  endtask : t_irq

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end
  initial begin
    // traffic needs about 50k core cycles
    repeat (80000) @(posedge clk);
    errors++;
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    strap = 2'b00;
    evt = 5'h0;
    dev = 7'h50;
    errors = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (16) @(posedge clk);
    chk("page", 18'h0, 18'(page_sel));
    t_addr();
    t_page();
    t_read();
    t_irq();
    test_done();
  end
endmodule : i2c_paged_register_port_tb
`default_nettype wire
